// File: dba_params.svh
// Purpose: constants for the data and program addressing block
// Assumes: 12-bit data space, 21-bit byte program counter
// Notes: definitions only
`ifndef DBA_PARAMS_SVH
`define DBA_PARAMS_SVH

// program counter
`define DBA_PC_RESET 21'h000000
`define DBA_PC_STEP 21'h000002

// bank register and data map
`define DBA_BANK_RESET 4'h0
`define DBA_BANK_SEL_ADDR 12'hfe0
`define DBA_GPR_LIMIT 12'hf40
`define DBA_RAM_BYTES 3904
`define DBA_ACCESS_SPLIT 8'h60
`define DBA_BANK_LOW 4'h0
`define DBA_BANK_SFR 4'hf

// instruction word fields
`define DBA_TAIL_NIBBLE 4'hf
`define DBA_MOVE_NIBBLE 4'hc
`define DBA_JUMP_BYTE 8'hef

`endif

// File: dba_pkg.sv
// Purpose: shared types of the addressing block
// Assumes: nothing beyond the params header
// Notes: one-hot codes written out
`default_nettype none
package dba_pkg;

	// sequencer of two-word instructions
	typedef enum logic [1:0] {
		DBA_IDLE = 2'b01,
		DBA_SECOND = 2'b10
	} dba_state_type;

	// what the pending first word asks for
	typedef enum logic [2:0] {
		DBA_K_MOVE = 3'b001,
		DBA_K_JUMP = 3'b010,
		DBA_K_LIT = 3'b100
	} dba_kind_type;

endpackage
`default_nettype wire

// File: dba_addr_map.sv
// Purpose: forms a 12-bit data address from an 8-bit operand
// Assumes: bank value already limited to four bits
// Notes: purely combinational
`timescale 1ns/1ns
`default_nettype none
`include "dba_params.svh"
module dba_addr_map (
	input wire logic [7:0] operand,
	input wire logic access_bit,
	input wire logic [3:0] bank,
	output logic [11:0] addr
);
	// quick-access window: low part to bank 0, the rest to the sfr bank
	logic low_part;
	logic [3:0] window_bank;

	assign low_part = operand < `DBA_ACCESS_SPLIT;
	assign window_bank = low_part ? `DBA_BANK_LOW : `DBA_BANK_SFR;
	// banked form: bank on top, operand below
	assign addr = access_bit ? {bank, operand} : {window_bank, operand};
endmodule
`default_nettype wire

// File: dba_core.sv
// Purpose: program counter, two-word sequencing and banked data memory
// Assumes: core drives one data request per cycle; usb port only when enabled
// Notes: sfr space other than the bank register reads zero here
`timescale 1ns/1ns
`default_nettype none
`include "dba_params.svh"
module dba_core (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic fetch_advance,
	input wire logic branch_valid,
	input wire logic [10:0] branch_offset,
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	input wire logic instr_ext_two_word,
	input wire logic instr_ext_is_call,
	input wire logic bank_load,
	input wire logic [7:0] bank_literal,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [7:0] mem_operand,
	input wire logic mem_access_bit,
	input wire logic [7:0] mem_wdata,
	input wire logic usb_enable,
	input wire logic usb_req,
	input wire logic usb_we,
	input wire logic [11:0] usb_addr,
	input wire logic [7:0] usb_wdata,
	output logic [20:0] program_counter,
	output logic [7:0] bank_select_register,
	output logic [11:0] mem_addr,
	output logic [7:0] mem_rdata,
	output logic status_update,
	output logic status_zero,
	output logic nop_executed,
	output logic literal_valid,
	output logic [11:0] literal_data,
	output logic move_done,
	output logic [7:0] usb_rdata
);
	dba_pkg::dba_state_type state_reg;
	dba_pkg::dba_state_type state_next;
	dba_pkg::dba_kind_type kind_reg;
	dba_pkg::dba_kind_type kind_first;
	logic [11:0] first_low_reg;
	logic [3:0] bank_reg;
	logic [3:0] bank_next;
	logic [20:0] pc_next;
	logic [7:0] ram [0:`DBA_RAM_BYTES-1];

	// true for locations backed by the general purpose array
	function automatic logic is_gpr(input logic [11:0] a);
		is_gpr = a < `DBA_GPR_LIMIT;
	endfunction

	// one read path for core, move and usb; anything unbacked gives zero
	function automatic logic [7:0] mem_read(input logic [11:0] a);
		if (a == `DBA_BANK_SEL_ADDR) begin
			mem_read = {4'h0, bank_reg};
		end else if (is_gpr(a)) begin
			mem_read = ram[a];
		end else begin
			mem_read = 8'h00;
		end
	endfunction

	// instruction word decode
	wire word_tail;
	wire first_move;
	wire first_jump;
	wire first_two;
	wire second_ok;
	wire lone_tail;
	wire jump_fire;
	wire move_fire;
	wire [19:0] jump_word;

	assign word_tail = instr_word[15:12] == `DBA_TAIL_NIBBLE;
	assign first_move = instr_word[15:12] == `DBA_MOVE_NIBBLE;
	assign first_jump = instr_word[15:8] == `DBA_JUMP_BYTE;
	assign first_two = first_move | first_jump | instr_ext_two_word;
	assign second_ok = instr_valid && state_reg == dba_pkg::DBA_SECOND && word_tail;
	// a tail word with no first word before it does nothing
	assign lone_tail = instr_valid && state_reg == dba_pkg::DBA_IDLE && word_tail;
	assign jump_fire = second_ok && kind_reg == dba_pkg::DBA_K_JUMP;
	assign move_fire = second_ok && kind_reg == dba_pkg::DBA_K_MOVE;
	// word address: literal of second word over low byte of first
	assign jump_word = {instr_word[11:0], first_low_reg[7:0]};

	// kind of the first word seen in idle
	always_comb begin
		if (first_move) begin
			kind_first = dba_pkg::DBA_K_MOVE;
		end else if (first_jump || instr_ext_is_call) begin
			kind_first = dba_pkg::DBA_K_JUMP;
		end else begin
			kind_first = dba_pkg::DBA_K_LIT;
		end
	end

	// sequencer; a non-tail word while waiting abandons the pair
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			dba_pkg::DBA_IDLE: begin
				if (instr_valid && !word_tail && first_two) begin
					state_next = dba_pkg::DBA_SECOND;
				end
			end
			dba_pkg::DBA_SECOND: begin
				if (instr_valid) begin
					state_next = dba_pkg::DBA_IDLE;
				end
			end
			default: begin
				state_next = dba_pkg::DBA_IDLE;
			end
		endcase
	end

	// sequencer state and captured first word
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= dba_pkg::DBA_IDLE;
			kind_reg <= dba_pkg::DBA_K_LIT;
			first_low_reg <= 12'h000;
		end else begin
			state_reg <= state_next;
			if (state_reg == dba_pkg::DBA_IDLE && instr_valid) begin
				kind_reg <= kind_first;
				first_low_reg <= instr_word[11:0];
			end
		end
	end

	// sequencer outputs; the literal is handed on only after its first word
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			nop_executed <= 1'b0;
			literal_valid <= 1'b0;
			literal_data <= 12'h000;
			move_done <= 1'b0;
		end else begin
			nop_executed <= lone_tail;
			literal_valid <= second_ok;
			move_done <= move_fire;
			if (second_ok) begin
				literal_data <= instr_word[11:0];
			end
		end
	end

	// program counter: absolute jump over branch over plain step
	wire [20:0] branch_bytes;
	wire [20:0] pc_raw;

	assign branch_bytes = {{9{branch_offset[10]}}, branch_offset, 1'b0};
	assign pc_raw = jump_fire ? {jump_word, 1'b0} :
		branch_valid ? program_counter + branch_bytes :
		fetch_advance ? program_counter + `DBA_PC_STEP :
		program_counter;
	// forcing bit 0 keeps every fetch on the even low byte
	assign pc_next = {pc_raw[20:1], 1'b0};

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			program_counter <= `DBA_PC_RESET;
		end else begin
			program_counter <= pc_next;
		end
	end

	// core data address through bank register or quick window
	wire [11:0] core_addr;

	dba_addr_map u_map (
		.operand(mem_operand),
		.access_bit(mem_access_bit),
		.bank(bank_reg),
		.addr(core_addr)
	);

	// full-address move uses both literals as is, never the bank
	wire [11:0] move_src;
	wire [11:0] move_dst;
	wire [7:0] move_data;

	assign move_src = first_low_reg;
	assign move_dst = instr_word[11:0];
	assign move_data = mem_read(move_src);

	// write enables; targets outside the array drop silently, save the bank register for core and move writes
	wire core_wr;
	wire move_wr;
	wire usb_live;
	wire usb_wr;

	assign core_wr = mem_req && mem_we && is_gpr(core_addr);
	assign move_wr = move_fire && is_gpr(move_dst);
	// usb port exists only while the engine is on; off, ram is plain core ram
	assign usb_live = usb_enable && usb_req;
	assign usb_wr = usb_live && usb_we && is_gpr(usb_addr);

	// shared array; written usb, then core, then move, so on a clash the last write, move, wins
	always_ff @(posedge clock) begin
		if (usb_wr) begin
			ram[usb_addr] <= usb_wdata;
		end
		if (core_wr) begin
			ram[core_addr] <= mem_wdata;
		end
		if (move_wr) begin
			ram[move_dst] <= move_data;
		end
	end

	// bank register: data writes keep only the low nibble
	wire core_bank_wr;
	wire move_bank_wr;

	assign core_bank_wr = mem_req && mem_we && core_addr == `DBA_BANK_SEL_ADDR;
	assign move_bank_wr = move_fire && move_dst == `DBA_BANK_SEL_ADDR;
	assign bank_next = bank_load ? bank_literal[3:0] :
		move_bank_wr ? move_data[3:0] :
		core_bank_wr ? mem_wdata[3:0] :
		bank_reg;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			bank_reg <= `DBA_BANK_RESET;
			bank_select_register <= 8'h00;
		end else begin
			bank_reg <= bank_next;
			bank_select_register <= {4'h0, bank_next};
		end
	end

	// core answer; flags follow even when the target was not there
	wire [7:0] core_result;

	assign core_result = mem_we ? mem_wdata : mem_read(core_addr);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mem_addr <= 12'h000;
			mem_rdata <= 8'h00;
			status_update <= 1'b0;
			status_zero <= 1'b0;
		end else begin
			status_update <= mem_req;
			if (mem_req) begin
				mem_addr <= core_addr;
				mem_rdata <= mem_we ? 8'h00 : mem_read(core_addr);
				status_zero <= core_result == 8'h00;
			end
		end
	end

	// usb read port; disabled engine sees zeros
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			usb_rdata <= 8'h00;
		end else if (usb_live && !usb_we) begin
			usb_rdata <= mem_read(usb_addr);
		end else begin
			usb_rdata <= 8'h00;
		end
	end

	// checks on counter, sequencing and data addressing
	a_pc_even: assert property (@(posedge clock) disable iff (!reset_n)
		program_counter[0] == 1'b0)
		else $error("program counter lsb not zero");
	a_pc_step_two: assert property (@(posedge clock) disable iff (!reset_n)
		fetch_advance && !branch_valid && !jump_fire |=>
		program_counter == $past(program_counter) + `DBA_PC_STEP)
		else $error("program counter did not step by two");
	a_jump_word_addr: assert property (@(posedge clock) disable iff (!reset_n)
		jump_fire |=> program_counter[20:1] == $past(jump_word) && move_done == 1'b0)
		else $error("absolute target not loaded into bits 20:1");
	a_branch_doubled: assert property (@(posedge clock) disable iff (!reset_n)
		branch_valid && !jump_fire |=> program_counter ==
		$past(program_counter) + {{9{$past(branch_offset[10])}}, $past(branch_offset), 1'b0})
		else $error("branch displacement not twice the offset");
	a_lone_tail_nop: assert property (@(posedge clock) disable iff (!reset_n)
		lone_tail |=> nop_executed && !literal_valid)
		else $error("lone tail word not a nop");
	a_tail_literal: assert property (@(posedge clock) disable iff (!reset_n)
		instr_valid && state_reg == dba_pkg::DBA_IDLE && !word_tail && first_two
		##1 instr_valid && word_tail |=> literal_valid && !nop_executed)
		else $error("second word literal not consumed");
	a_bank_upper_zero: assert property (@(posedge clock) disable iff (!reset_n)
		bank_select_register[7:4] == 4'h0)
		else $error("bank register upper bits not zero");
	a_bank_load: assert property (@(posedge clock) disable iff (!reset_n)
		bank_load |=> bank_select_register == {4'h0, $past(bank_literal[3:0])})
		else $error("bank load literal not taken");
	a_banked_addr: assert property (@(posedge clock) disable iff (!reset_n)
		mem_req && mem_access_bit |=> mem_addr == {$past(bank_reg), $past(mem_operand)})
		else $error("banked address not bank over operand");
	a_window_map: assert property (@(posedge clock) disable iff (!reset_n)
		mem_req && !mem_access_bit |=> mem_addr[11:8] ==
		(($past(mem_operand) < `DBA_ACCESS_SPLIT) ? `DBA_BANK_LOW : `DBA_BANK_SFR))
		else $error("quick window mapped to wrong bank");
	a_unimpl_zero: assert property (@(posedge clock) disable iff (!reset_n)
		mem_req && !mem_we && !is_gpr(core_addr) && core_addr != `DBA_BANK_SEL_ADDR
		|=> mem_rdata == 8'h00 && status_update)
		else $error("unimplemented read not zero or flags not updated");
	a_usb_off_quiet: assert property (@(posedge clock) disable iff (!reset_n)
		!usb_enable |=> usb_rdata == 8'h00)
		else $error("usb port answered while disabled");
endmodule
`default_nettype wire

// File: dba_usb_model.sv
// Purpose: usb engine stand-in driving the shared ram port
// Assumes: one transfer at a time, launched from the bench
// Notes: released lines show inverted values so stale data never looks valid
`timescale 1ns/1ns
`default_nettype none
module dba_usb_model (
	input wire logic clock,
	output logic usb_req,
	output logic usb_we,
	output logic [11:0] usb_addr,
	output logic [7:0] usb_wdata
);
	// idle levels from time zero
	initial begin
		usb_req = 1'b0;
		usb_we = 1'b0;
		usb_addr = 12'h000;
		usb_wdata = 8'h00;
	end

	// one access, held until the taking edge, then released
	task automatic xfer(input logic we, input logic [11:0] a, input logic [7:0] d);
		@(posedge clock);
		usb_req <= 1'b1;
		usb_we <= we;
		usb_addr <= a;
		usb_wdata <= d;
		@(posedge clock);
		usb_req <= 1'b0;
		usb_addr <= ~a;
		usb_wdata <= ~d;
		#1;
	endtask
endmodule
`default_nettype wire

// File: tb.sv
// Purpose: directed checks of addressing, banking and two-word sequencing
// Assumes: one access per task call, outputs sampled 1 ns after the taking edge
// Notes: usb traffic keeps clear of bank 4 while the engine is on
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic clock, reset_n, fetch_advance, branch_valid, instr_valid;
	logic instr_ext_two_word, instr_ext_is_call, bank_load, mem_req, mem_we;
	logic mem_access_bit, usb_enable, usb_req, usb_we;
	logic [10:0] branch_offset;
	logic [15:0] instr_word;
	logic [7:0] bank_literal, mem_operand, mem_wdata, usb_wdata, mem_rdata, usb_rdata;
	logic [11:0] usb_addr, mem_addr, literal_data;
	logic [20:0] program_counter;
	logic [7:0] bank_select_register;
	logic status_update, status_zero, nop_executed, literal_valid, move_done;
	int miscompares = 0;
	int n_compared = 0;

	dba_core i_dba_core (.clock, .reset_n, .fetch_advance, .branch_valid, .branch_offset,
		.instr_valid, .instr_word, .instr_ext_two_word, .instr_ext_is_call, .bank_load,
		.bank_literal, .mem_req, .mem_we, .mem_operand, .mem_access_bit, .mem_wdata,
		.usb_enable, .usb_req, .usb_we, .usb_addr, .usb_wdata, .program_counter,
		.bank_select_register, .mem_addr, .mem_rdata, .status_update, .status_zero,
		.nop_executed, .literal_valid, .literal_data, .move_done, .usb_rdata);
	dba_usb_model i_dba_usb_model (.clock, .usb_req, .usb_we, .usb_addr, .usb_wdata);

	// 50 MHz clock
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t ns: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report;
		$display("compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// core data access, released with inverted lines
	task automatic mem(input logic we, input logic a, input logic [7:0] op, input logic [7:0] d);
		@(posedge clock);
		mem_req <= 1'b1;
		mem_we <= we;
		mem_access_bit <= a;
		mem_operand <= op;
		mem_wdata <= d;
		@(posedge clock);
		mem_req <= 1'b0;
		mem_operand <= ~op;
		mem_wdata <= ~d;
		#1;
	endtask

	task automatic bl(input logic [7:0] lit);
		@(posedge clock);
		bank_load <= 1'b1;
		bank_literal <= lit;
		@(posedge clock);
		bank_load <= 1'b0;
		#1;
	endtask

	task automatic ins(input logic [15:0] w, input logic ext, input logic call);
		@(posedge clock);
		instr_valid <= 1'b1;
		instr_word <= w;
		instr_ext_two_word <= ext;
		instr_ext_is_call <= call;
		@(posedge clock);
		instr_valid <= 1'b0;
		instr_ext_two_word <= 1'b0;
		#1;
	endtask

	// first and second word on consecutive edges, no gap between them
	task automatic pair(input logic [15:0] w1, input logic ext, input logic [15:0] w2);
		@(posedge clock);
		instr_valid <= 1'b1;
		instr_word <= w1;
		instr_ext_two_word <= ext;
		instr_ext_is_call <= 1'b0;
		@(posedge clock);
		instr_word <= w2;
		instr_ext_two_word <= 1'b0;
		@(posedge clock);
		instr_valid <= 1'b0;
		#1;
	endtask

	task automatic done(input string name);
		$display("test %s finished", name);
	endtask

	// hang guard, well past the hundred or so cycles the tests need
	initial begin
		#40000;
		miscompares++;
		final_report;
	end

	initial begin
		{fetch_advance, branch_valid, instr_valid, instr_ext_two_word} = 4'h0;
		{instr_ext_is_call, bank_load, mem_req, mem_we, mem_access_bit, usb_enable} = 6'h00;
		branch_offset = 11'h000;
		instr_word = 16'h0000;
		bank_literal = 8'h00;
		mem_operand = 8'h00;
		mem_wdata = 8'h00;
		reset_n = 1'b0;
		repeat (16) @(posedge clock);
		reset_n <= 1'b1;
		#1;
		chk(program_counter, 21'h000000);
		chk(bank_select_register, 8'h00);
		// program counter and two-word ops
		@(posedge clock);
		fetch_advance <= 1'b1;
		@(posedge clock);
		fetch_advance <= 1'b0;
		#1;
		chk(program_counter, 21'h000002);
		ins(16'hef03, 1'b0, 1'b0);
		ins(16'hf000, 1'b0, 1'b0);
		chk(program_counter, 21'h000006);
		chk(literal_valid, 1'b1);
		ins(16'hf456, 1'b0, 1'b0);
		chk(nop_executed, 1'b1);
		@(posedge clock);
		branch_valid <= 1'b1;
		branch_offset <= 11'h7fe;
		@(posedge clock);
		branch_valid <= 1'b0;
		#1;
		chk(program_counter, 21'h000002);
		ins(16'hec05, 1'b1, 1'b1);
		ins(16'hf001, 1'b0, 1'b0);
		chk(program_counter, 21'h00020a);
		ins(16'hec00, 1'b1, 1'b0);
		ins(16'hf123, 1'b0, 1'b0);
		chk(literal_data, 12'h123);
		chk(program_counter, 21'h00020a);
		pair(16'hec00, 1'b1, 16'hf7bc);
		chk(literal_valid, 1'b1);
		chk(literal_data, 12'h7bc);
		chk(program_counter, 21'h00020a);
		done("program");
		// banked and quick-window addressing
		bl(8'ha5);
		chk(bank_select_register, 8'h05);
		mem(1'b1, 1'b1, 8'h33, 8'h5a);
		chk(mem_addr, 12'h533);
		chk(status_zero, 1'b0);
		mem(1'b0, 1'b1, 8'h33, 8'h00);
		chk(mem_rdata, 8'h5a);
		mem(1'b1, 1'b0, 8'h10, 8'h00);
		chk(mem_addr, 12'h010);
		chk(status_zero, 1'b1);
		mem(1'b0, 1'b0, 8'h70, 8'h00);
		chk(mem_addr, 12'hf70);
		chk(mem_rdata, 8'h00);
		bl(8'h0f);
		mem(1'b1, 1'b1, 8'h40, 8'h55);
		chk(mem_addr, 12'hf40);
		mem(1'b0, 1'b1, 8'h40, 8'h00);
		chk(mem_rdata, 8'h00);
		chk(status_update, 1'b1);
		mem(1'b1, 1'b1, 8'he0, 8'hf3);
		chk(bank_select_register, 8'h03);
		mem(1'b0, 1'b0, 8'he0, 8'h00);
		chk(mem_rdata, 8'h03);
		done("banking");
		// full-address move ignores the bank register
		bl(8'h01);
		mem(1'b1, 1'b1, 8'h23, 8'h77);
		bl(8'h07);
		ins(16'hc123, 1'b0, 1'b0);
		ins(16'hf456, 1'b0, 1'b0);
		chk(move_done, 1'b1);
		bl(8'h04);
		mem(1'b0, 1'b1, 8'h56, 8'h00);
		chk(mem_rdata, 8'h77);
		ins(16'hc123, 1'b0, 1'b0);
		ins(16'h0000, 1'b0, 1'b0);
		ins(16'hf456, 1'b0, 1'b0);
		chk(nop_executed, 1'b1);
		chk(move_done, 1'b0);
		done("move");
		// shared ram with usb engine, bank 4 left untouched meanwhile
		@(posedge clock);
		usb_enable <= 1'b1;
		i_dba_usb_model.xfer(1'b1, 12'h300, 8'h9a);
		bl(8'h03);
		mem(1'b0, 1'b1, 8'h00, 8'h00);
		chk(mem_rdata, 8'h9a);
		mem(1'b1, 1'b1, 8'h01, 8'h3c);
		i_dba_usb_model.xfer(1'b0, 12'h301, 8'h00);
		chk(usb_rdata, 8'h3c);
		@(posedge clock);
		usb_enable <= 1'b0;
		i_dba_usb_model.xfer(1'b0, 12'h301, 8'h00);
		chk(usb_rdata, 8'h00);
		done("usb");
		final_report;
	end
endmodule
`default_nettype wire
